// ---- rtl/fal_pkg.sv ----
// package for the fault alert latch, bits 15..7 of the supply/osc/comm register
package fal_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] FAL_REG_OFFSET = 8'h05;
	localparam logic [15:0] FAL_RESET_VALUE = 16'h0000;
	localparam int FAL_BIT_OSC_PRI = 15;
	localparam int FAL_BIT_OSC_RED = 14;
	localparam int FAL_BIT_UP_SE_PRI = 13;
	localparam int FAL_BIT_LO_SE_PRI = 12;
	localparam int FAL_BIT_UP_SE_RED = 11;
	localparam int FAL_BIT_LO_SE_RED = 10;
	localparam int FAL_BIT_SUP3 = 9;
	localparam int FAL_BIT_SUP2 = 8;
	localparam int FAL_BIT_SUP1 = 7;
	localparam int FAL_LOW_BIT = 7;

	// ------------------------------------------------------------
	// oscillator cross-check
	// ------------------------------------------------------------
	localparam int FAL_TOL_PERCENT = 5;
	localparam int FAL_LF_CYCLES_PER_EVAL = 2;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic up_se;
		logic lo_se;
		logic sup3;
		logic sup2;
		logic sup1;
	} fal_cond_s;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [15:0] data;
	} fal_wr_s;

endpackage : fal_pkg

// ---- rtl/fal_fault_alert_latch_upper.sv ----
// fault alert latch: bits 15..7 of the supply/osc/comm alert register
//
// Contract
// - set primary osc fault when low-freq osc deviates beyond tolerance
// - re-evaluate osc fault once every two low-freq osc cycles
// - primary osc fault clears only on write 0 with condition gone
// - lower-port single-ended alert sets when lower receiver goes single-ended
// - upper-port single-ended alert sets when upper receiver goes single-ended
// - primary single-ended alerts do not set while reset pending; read-only
// - redundant single-ended copies read-only and may set while pending
// - supply faults set on undervoltage, not while reset pending
// - supply faults clear only on write 0 with supply recovered
// - all fields reset to 0; bits 13..10 read-only
`timescale 1ns/1ps
module fal_fault_alert_latch_upper #(
	parameter int HF_CNT_W = 16,
	parameter logic [15:0] HF_PER_EVAL_NOM = 16'h0190
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire fal_pkg::fal_wr_s reg_wr,
	input wire logic alert_reset_pending,
	input wire fal_pkg::fal_cond_s cond,
	input wire logic low_freq_oscillator_tick,
	output logic [15:0] rd_data,
	output logic osc_fault_condition
);

	// ------------------------------------------------------------
	// oscillator cross-check
	// ------------------------------------------------------------
	// high-freq oscillator is mclk; window spans two low-freq edges
	logic [HF_CNT_W-1:0] hf_cnt_q, hf_cnt_d;
	localparam int LF_LAST = fal_pkg::FAL_LF_CYCLES_PER_EVAL - 1;
	localparam int LF_CNT_W =
		$clog2(fal_pkg::FAL_LF_CYCLES_PER_EVAL + 1);
	logic [LF_CNT_W-1:0] lf_cnt_q, lf_cnt_d;
	logic hf_full;
	logic osc_bad_q, osc_bad_d;
	logic eval_now;
	logic [HF_CNT_W+7:0] scaled;
	logic [HF_CNT_W+7:0] lo_lim, hi_lim;

	assign lo_lim = (HF_CNT_W+8)'(HF_PER_EVAL_NOM) * (HF_CNT_W+8)'(
		100 - fal_pkg::FAL_TOL_PERCENT);
	assign hi_lim = (HF_CNT_W+8)'(HF_PER_EVAL_NOM) * (HF_CNT_W+8)'(
		100 + fal_pkg::FAL_TOL_PERCENT);
	assign scaled = (HF_CNT_W+8)'(hf_cnt_q) * (HF_CNT_W+8)'(100);
	assign hf_full = (hf_cnt_q == {HF_CNT_W{1'b1}});
	assign eval_now = low_freq_oscillator_tick
		&& (lf_cnt_q == LF_CNT_W'(LF_LAST));

	always_comb begin
		hf_cnt_d = hf_cnt_q;
		lf_cnt_d = lf_cnt_q;
		osc_bad_d = osc_bad_q;
		// saturate so a very slow low-freq clock cannot wrap into range
		if (!hf_full) begin
			hf_cnt_d = hf_cnt_q + HF_CNT_W'(1);
		end
		if (low_freq_oscillator_tick) begin
			lf_cnt_d = lf_cnt_q + LF_CNT_W'(1);
		end
		if (eval_now) begin
			osc_bad_d = (scaled < lo_lim) || (scaled > hi_lim);
			// the evaluating edge already counts as the next window's first
			hf_cnt_d = HF_CNT_W'(1);
			lf_cnt_d = '0;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			hf_cnt_q <= '0;
			lf_cnt_q <= '0;
			osc_bad_q <= 1'b0;
		end else begin
			hf_cnt_q <= hf_cnt_d;
			lf_cnt_q <= lf_cnt_d;
			osc_bad_q <= osc_bad_d;
		end
	end

	// ------------------------------------------------------------
	// alert latches
	// ------------------------------------------------------------
	logic osc_fault_primary_q, osc_fault_primary_d;
	logic osc_fault_redundant_q, osc_fault_redundant_d;
	logic upper_port_single_ended_primary_d;
	logic lower_port_single_ended_primary_d;
	logic upper_port_single_ended_redundant_d;
	logic lower_port_single_ended_redundant_d;
	logic [1:0] se_cond;
	wire logic [1:0] se_pri_d;
	wire logic [1:0] se_red_d;
	logic [2:0] sup_cond;
	wire logic [2:0] core_supply_fault_d;
	logic hit;

	// set wins over a concurrent clear; write 1 never changes a bit
	function automatic logic w0c(
		input logic cur,
		input logic set,
		input logic wr,
		input logic wbit,
		input logic cond_now
	);
		logic clr_ok;
		// a 0 is only honoured once the fault condition has gone
		clr_ok = wr & ~wbit & ~cond_now;
		w0c = set | (cur & ~clr_ok);
	endfunction : w0c

	assign hit = reg_wr.wr && (reg_wr.addr == fal_pkg::FAL_REG_OFFSET);
	assign se_cond = {cond.up_se, cond.lo_se};
	assign sup_cond = {cond.sup3, cond.sup2, cond.sup1};
	assign upper_port_single_ended_primary_d = se_pri_d[1];
	assign lower_port_single_ended_primary_d = se_pri_d[0];
	assign upper_port_single_ended_redundant_d = se_red_d[1];
	assign lower_port_single_ended_redundant_d = se_red_d[0];

	always_comb begin
		osc_fault_primary_d = w0c(osc_fault_primary_q, osc_bad_q, hit,
			reg_wr.data[fal_pkg::FAL_BIT_OSC_PRI], osc_bad_q);
		// own latch: clearing one copy never touches the other
		osc_fault_redundant_d = w0c(osc_fault_redundant_q, osc_bad_q, hit,
			reg_wr.data[fal_pkg::FAL_BIT_OSC_RED], osc_bad_q);
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			osc_fault_primary_q <= 1'b0;
			osc_fault_redundant_q <= 1'b0;
		end else begin
			osc_fault_primary_q <= osc_fault_primary_d;
			osc_fault_redundant_q <= osc_fault_redundant_d;
		end
	end

	// ------------------------------------------------------------
	// single-ended receiver alerts, read-only
	// ------------------------------------------------------------
	// index 1 is the upper port, index 0 the lower port
	for (genvar p = 0; p < 2; p++) begin : gen_port
		logic pri_q, pri_d;
		logic red_q, red_d;

		// sticky until reset: software has no clear path
		always_comb begin
			pri_d = pri_q | (se_cond[p] & ~alert_reset_pending);
			red_d = red_q | se_cond[p];
		end

		always_ff @(posedge mclk) begin
			if (sys_rst) begin
				pri_q <= 1'b0;
				red_q <= 1'b0;
			end else begin
				pri_q <= pri_d;
				red_q <= red_d;
			end
		end

		assign se_pri_d[p] = pri_d;
		assign se_red_d[p] = red_d;
	end

	// ------------------------------------------------------------
	// internal supply fault latches
	// ------------------------------------------------------------
	// the pending flag masks only the set path, never a clear
	for (genvar g = 0; g < 3; g++) begin : gen_supply
		logic flag_q, flag_d;

		always_comb begin
			flag_d = w0c(flag_q, sup_cond[g] & ~alert_reset_pending, hit,
				reg_wr.data[fal_pkg::FAL_BIT_SUP1 + g], sup_cond[g]);
		end

		always_ff @(posedge mclk) begin
			if (sys_rst) begin
				flag_q <= 1'b0;
			end else begin
				flag_q <= flag_d;
			end
		end

		assign core_supply_fault_d[g] = flag_d;
	end

	// ------------------------------------------------------------
	// read data, registered
	// ------------------------------------------------------------
	// built from next-state values so the image lands on the latching edge
	logic [15:0] rd_data_d;

	always_comb begin
		rd_data_d = fal_pkg::FAL_RESET_VALUE;
		rd_data_d[fal_pkg::FAL_BIT_OSC_PRI] = osc_fault_primary_d;
		rd_data_d[fal_pkg::FAL_BIT_OSC_RED] = osc_fault_redundant_d;
		rd_data_d[fal_pkg::FAL_BIT_UP_SE_PRI] =
			upper_port_single_ended_primary_d;
		rd_data_d[fal_pkg::FAL_BIT_LO_SE_PRI] =
			lower_port_single_ended_primary_d;
		rd_data_d[fal_pkg::FAL_BIT_UP_SE_RED] =
			upper_port_single_ended_redundant_d;
		rd_data_d[fal_pkg::FAL_BIT_LO_SE_RED] =
			lower_port_single_ended_redundant_d;
		rd_data_d[fal_pkg::FAL_BIT_SUP3:fal_pkg::FAL_BIT_SUP1] =
			core_supply_fault_d;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rd_data <= fal_pkg::FAL_RESET_VALUE;
			osc_fault_condition <= 1'b0;
		end else begin
			rd_data <= rd_data_d;
			osc_fault_condition <= osc_bad_d;
		end
	end

endmodule : fal_fault_alert_latch_upper

// ---- verification/fal_fault_alert_latch_upper_sva.sv ----
// checker for the fault alert latch register image
`timescale 1ns/1ps
module fal_chk (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire fal_pkg::fal_wr_s reg_wr,
	input wire logic alert_reset_pending,
	input wire fal_pkg::fal_cond_s cond,
	input wire logic low_freq_oscillator_tick,
	input wire logic [15:0] rd_data,
	input wire logic osc_fault_condition
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	wire logic hit = reg_wr.wr && reg_wr.addr == fal_pkg::FAL_REG_OFFSET;
	AST_RST: assert property (disable iff (1'b0)
		sys_rst |=> rd_data == 16'h0000) else $error("reset value");
	AST_SUP_SET: assert property (!alert_reset_pending && cond.sup1
		|=> rd_data[7]) else $error("supply bit not set");
	AST_SUP_PEND: assert property (alert_reset_pending && !rd_data[9]
		|=> !rd_data[9]) else $error("supply bit set while pending");
	AST_SUP_KEEP: assert property (rd_data[8] && !(hit &&
		!reg_wr.data[8] && !cond.sup2) |=> rd_data[8]) else $error("lost");
	AST_SUP_CLR: assert property (hit && !reg_wr.data[9] && !cond.sup3
		|=> !rd_data[9]) else $error("supply bit not cleared");
	AST_SE_PEND: assert property (alert_reset_pending && !rd_data[12]
		|=> !rd_data[12]) else $error("primary copy set while pending");
	AST_SE_STICK: assert property (1'b1
		|=> ($past(rd_data[13:10]) & ~rd_data[13:10]) == 4'h0)
		else $error("read-only bit fell");
	AST_SE_RED: assert property (cond.lo_se |=> rd_data[10])
		else $error("redundant copy not set");
	AST_SE_UP: assert property (!alert_reset_pending && cond.up_se
		|=> rd_data[13]) else $error("upper primary not set");
	AST_OSC_SET: assert property ($rose(osc_fault_condition)
		|=> rd_data[15] && rd_data[14]) else $error("osc bits not set");
	AST_OSC_KEEP: assert property (rd_data[15] && osc_fault_condition
		|=> rd_data[15]) else $error("osc bit cleared while faulty");
	AST_OSC_EVAL: assert property ($changed(osc_fault_condition)
		|-> $past(low_freq_oscillator_tick)) else $error("osc off tick");
endmodule : fal_chk
bind fal_fault_alert_latch_upper fal_chk fal_chk_inst (.mclk(mclk),
	.sys_rst(sys_rst), .reg_wr(reg_wr), .cond(cond), .rd_data(rd_data),
	.alert_reset_pending(alert_reset_pending),
	.low_freq_oscillator_tick(low_freq_oscillator_tick),
	.osc_fault_condition(osc_fault_condition));

// ---- verification/fal_fault_alert_latch_upper_test.sv ----
// self-checking bench for the fault alert latch
`timescale 1ns/1ps
module fal_fault_alert_latch_upper_test;
	logic mclk = 0, sys_rst = 1, pend = 1, tick = 0, osc;
	fal_pkg::fal_wr_s reg_wr = '0;
	fal_pkg::fal_cond_s cond = '0;
	logic [15:0] rd_data, e, d;
	logic [7:0] a;
	logic [2:0] s;
	int n_fail = 0, check_count = 0, per = 20, tc = 0;
	// nominal 40 clocks per two ticks keeps the run short
	fal_fault_alert_latch_upper #(.HF_PER_EVAL_NOM(16'h0028))
	fal_fault_alert_latch_upper_inst (.mclk(mclk), .sys_rst(sys_rst),
		.reg_wr(reg_wr), .alert_reset_pending(pend), .cond(cond),
		.low_freq_oscillator_tick(tick), .rd_data(rd_data),
		.osc_fault_condition(osc));
	initial forever #2.5 mclk = ~mclk;
	always @(posedge mclk) begin
		tc <= sys_rst || tc >= per - 1 ? 0 : tc + 1;
		tick <= tc == per - 1;
	end
	task automatic complete_run;
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	task automatic cmp(input logic [15:0] g, x);
		check_count++;
		if (g !== x) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
		end
	endtask : cmp
	task automatic chk(input logic [15:0] x);
		@(posedge mclk);
		#1 cmp(rd_data, x);
	endtask : chk
	task automatic wr(input logic [7:0] ad, input logic [15:0] dt);
		@(posedge mclk) reg_wr <= '{1'b1, ad, dt};
		@(posedge mclk) reg_wr.wr <= 1'b0;
	endtask : wr
	task automatic wosc(input logic v);
		for (int i = 0; i < 400 && osc !== v; i++) begin
			@(posedge mclk);
			#1;
		end
		cmp({15'h0, osc}, {15'h0, v});
		if (osc !== v) complete_run();
	endtask : wosc
	// write-0 clears bits 9..7 only where the live condition is gone; bits 15..14 clear on any 0
	function automatic logic [15:0] clr(logic [15:0] c, w, logic [2:0] l);
		return c & {w[15:14], 4'hf, w[9:7] | l, 7'h00};
	endfunction : clr
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(99));
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		chk(16'h0000);
		repeat (120) @(posedge mclk);
		wr(8'h05, 16'h0000);
		cond <= 5'h1f;
		chk(16'h0c00);
		wr(8'h05, 16'h0000);
		chk(16'h0c00);
		@(posedge mclk) pend <= 1'b0;
		chk(16'h3f80);
		wr(8'h05, 16'h0000);
		chk(16'h3f80);
		wr(8'h05, 16'hffff);
		chk(16'h3f80);
		e = 16'h3f80;
		repeat (12) begin
			s = 3'($urandom);
			d = 16'($urandom);
			a = $urandom % 2 ? 8'h05 : 8'($urandom);
			@(posedge mclk) cond <= {2'b11, s};
			e = e | {6'h0, s, 7'h0};
			wr(a, d);
			if (a == 8'h05) e = clr(e, d, s);
			chk(e);
		end
		@(posedge mclk) per <= 30;
		wosc(1'b1);
		chk(e | 16'hc000);
		wr(8'h05, 16'h3fff);
		chk(e | 16'hc000);
		@(posedge mclk) per <= 20;
		wosc(1'b0);
		wr(8'h05, 16'h3fff);
		chk(e);
		@(posedge mclk) sys_rst <= 1'b1;
		chk(16'h0000);
		@(posedge mclk) sys_rst <= 1'b0;
		chk(16'h3c00 | {6'h0, s, 7'h0});
		cmp({15'h0, osc}, 16'h0000);
		complete_run();
	end
endmodule : fal_fault_alert_latch_upper_test
